/* File: hdl/flash_seq_consts.vh */
// constants for the security page, pause and soft reset sequencer
// assumes a 200 MHz system clock and a host-driven serial link
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH

// system clock period in ns
`define MCLK_PERIOD_NS      5

// opcodes handled or screened here
`define OP_WRITE_ARM        8'h06
`define OP_PUMP_MODE        8'hA3
`define OP_RELEASE          8'hAB
`define OP_POWER_DOWN       8'hB9
`define OP_PAUSE            8'h75
`define OP_CONTINUE         8'h7A
`define OP_SEC_ERASE        8'h44
`define OP_SEC_PROG         8'h42
`define OP_SEC_READ         8'h48
`define OP_RESET_ENABLE     8'h66
`define OP_RESET            8'h99
`define OP_STATUS_WRITE     8'h01
`define OP_ERASE_SECTOR     8'h20
`define OP_ERASE_32K        8'h52
`define OP_ERASE_64K        8'hD8
`define OP_ERASE_CHIP_A     8'hC7
`define OP_ERASE_CHIP_B     8'h60
`define OP_PAGE_PROG        8'h02
`define OP_QUAD_PAGE_PROG   8'h32

// frame lengths in bytes
`define LEN_SINGLE          3'd1
`define LEN_PUMP            3'd4
`define LEN_SEC_ERASE       3'd4
`define LEN_SEC_PROG_MIN    3'd5
`define IDX_ADDR_HI         3'd1
`define IDX_ADDR_MID        3'd2
`define IDX_ADDR_LO         3'd3
`define IDX_DUMMY           3'd4
`define BIT_LAST            3'd7

// security page layout
`define SEC_PAGES           4
`define SEC_PAGE_BYTES      256
`define SEC_PAGE_MAX        8'h03
`define SEC_ERASED          8'hFF

// times, in their own units (arbitrary where no figure is known)
`define PAUSE_LATENCY_NS    20000
`define CONTINUE_BOUND_NS   200
`define SEC_ERASE_TIME_US   1000
`define SEC_WRITE_TIME_US   500
`define SOFT_RESET_TIME_US  30

// longest time: rounded down
`define PAUSE_LATENCY_CYC   (`PAUSE_LATENCY_NS / `MCLK_PERIOD_NS)
// least times: rounded up
`define SEC_ERASE_CYC       ((`SEC_ERASE_TIME_US * 1000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define SEC_WRITE_CYC       ((`SEC_WRITE_TIME_US * 1000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define SOFT_RESET_CYC      ((`SOFT_RESET_TIME_US * 1000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

/* File: hdl/flash_seq.v */
// serial command sequencer: charge-pump mode, pause/continue, security pages, soft reset
// assumes the host drives select, serial clock and data slower than mclk/4
//
// Behaviour
// - pump-mode opcode plus three dummy bytes in one frame enters charge_pump_mode.
// - release or power-down opcode leaves charge_pump_mode.
// - pause taken only during array program/erase, not paused, op in progress.
// - pause sets paused flag now, drops op_in_progress within pause latency.
// - program pause refuses status write, security erase/program, erases, page programs.
// - erase pause refuses status write, security erase and all array erases.
// - continue taken only when paused and op_in_progress is low.
// - continue clears paused flag at once, raises op_in_progress, finishes operation.
// - four independent security pages of 256 bytes each.
// - security erase needs opcode plus exactly three address bytes, byte-aligned.
// - security erase/program run only with write_latch_armed set.
// - select rise starts timed cycle; busy held; latch cleared before completion.
// - otp_lock_flag set ignores every security erase and program.
// - security program frame holds opcode, three address bytes, one or more data.
// - address high byte zero, middle byte 00-03 page, low byte offset.
// - security read: opcode, address, dummy in; data out on falling edges.
// - read address advances per byte, low byte wraps FF to 00.
// - reset acts only right after a separate enable-reset frame.
// - accepted reset aborts operations and clears all volatile state.
// - no commands accepted during soft reset time.
// - write-arm, pause, continue, enable-reset and reset only act when select rises after bit eight.
`timescale 1ns/100ps
`include "flash_seq_consts.vh"
`default_nettype none

module flash_seq
#(
   parameter SEC_ERASE_CYC  = `SEC_ERASE_CYC,
   parameter SEC_WRITE_CYC  = `SEC_WRITE_CYC,
   parameter SOFT_RESET_CYC = `SOFT_RESET_CYC
)
(
   // clock and reset
   input  wire       mclk,
   input  wire       rst_n,
   // serial link pins
   input  wire       sel_n_pin,
   input  wire       sclk_pin,
   input  wire       sdi_pin,
   output wire       sdo,
   output wire       sdo_oe,
   // array engine side
   input  wire       array_busy,
   input  wire       array_is_erase,
   output reg        array_hold,
   output reg        array_abort,
   // status flags
   input  wire       otp_lock_flag,
   output reg        op_in_progress,
   output reg        paused_op_flag,
   output reg        write_latch_armed,
   output reg        charge_pump_mode,
   output reg        volatile_clear,
   output reg        soft_reset_busy,
   // commands passed on or refused
   output reg  [7:0] fwd_opcode,
   output reg        fwd_strobe,
   output reg        cmd_refused
);

   localparam ST_IDLE  = 4'b0001;
   localparam ST_ERASE = 4'b0010;
   localparam ST_PROG  = 4'b0100;
   localparam ST_RESET = 4'b1000;

   // counter loads, cut to register width
   localparam [31:0] PAUSE_LOAD = `PAUSE_LATENCY_CYC - 2;
   localparam [31:0] ERASE_LOAD = SEC_ERASE_CYC;
   localparam [31:0] WRITE_LOAD = SEC_WRITE_CYC;
   localparam [31:0] RESET_LOAD = SOFT_RESET_CYC;

   reg        sel_s1, sel_s2, sel_d;
   reg        sclk_s1, sclk_s2, sclk_d;
   reg        sdi_s1, sdi_s2;
   reg  [2:0] bit_cnt;
   reg  [2:0] nbytes;
   reg  [7:0] shift_in;
   reg  [7:0] opcode;
   reg  [7:0] addr_hi;
   reg  [7:0] addr_mid;
   reg  [7:0] addr_lo;
   reg        streaming;
   reg  [7:0] shift_out;
   reg        reset_armed;
   reg        halted;
   reg        paused_is_erase;
   reg [11:0] pause_cnt;
   reg  [3:0] state;
   reg [23:0] timer;
   reg  [1:0] op_page;
   reg  [7:0] mem   [0:`SEC_PAGES*`SEC_PAGE_BYTES-1];
   reg  [7:0] pbuf  [0:`SEC_PAGE_BYTES-1];
   reg        pmask [0:`SEC_PAGE_BYTES-1];

   wire       sel_rise  = sel_s2 & ~sel_d;
   wire       sel_fall  = ~sel_s2 & sel_d;
   wire       sclk_rise = ~sel_s2 & sclk_s2 & ~sclk_d;
   wire       sclk_fall = ~sel_s2 & ~sclk_s2 & sclk_d;
   wire       byte_done = sclk_rise & (bit_cnt == `BIT_LAST);
   wire [7:0] new_byte  = {shift_in[6:0], sdi_s2};
   wire       aligned   = (bit_cnt == 3'd0);
   wire       single    = aligned & (nbytes == `LEN_SINGLE);
   wire       sec_busy  = (state == ST_ERASE) | (state == ST_PROG);
   // data byte of a program frame goes to the staging buffer
   wire       pb_we     = byte_done & (opcode == `OP_SEC_PROG) & (nbytes >= `IDX_DUMMY);
   wire       pb_clr    = byte_done & (nbytes == 3'd0);
   wire       sec_done  = sec_busy & (timer == 24'd1);
   wire       page_ok   = (addr_hi == 8'h00) & (addr_mid <= `SEC_PAGE_MAX);
   wire       sec_ok    = write_latch_armed & ~otp_lock_flag & ~op_in_progress &
                          ~paused_op_flag & page_ok & (state == ST_IDLE);
   wire       prog_ok   = write_latch_armed & ~otp_lock_flag & ~op_in_progress &
                          ~(paused_op_flag & ~paused_is_erase) & page_ok &
                          (state == ST_IDLE);
   reg        refused;

   assign sdo    = shift_out[7];
   assign sdo_oe = streaming & ~sel_s2;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always @(posedge mclk)
   begin
      sel_s1  <= sel_n_pin;
      sel_s2  <= sel_s1;
      sel_d   <= sel_s2;
      sclk_s1 <= sclk_pin;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      sdi_s1  <= sdi_pin;
      sdi_s2  <= sdi_s1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // refused opcodes while paused
   always @*
   begin
      refused = 1'b0;
      if (paused_op_flag)
      begin
         case (opcode)
            `OP_STATUS_WRITE, `OP_SEC_ERASE, `OP_ERASE_SECTOR, `OP_ERASE_32K,
            `OP_ERASE_64K, `OP_ERASE_CHIP_A, `OP_ERASE_CHIP_B:
               refused = 1'b1;
            `OP_SEC_PROG, `OP_PAGE_PROG, `OP_QUAD_PAGE_PROG:
               refused = ~paused_is_erase;
            default:
               refused = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame receiver and read streamer
   always @(posedge mclk)
   begin
      if (!rst_n || sel_fall)
      begin
         bit_cnt   <= 3'd0;
         nbytes    <= 3'd0;
         shift_in  <= 8'h00;
         streaming <= 1'b0;
         shift_out <= 8'h00;
         if (!rst_n)
         begin
            opcode   <= 8'h00;
            addr_hi  <= 8'h00;
            addr_mid <= 8'h00;
            addr_lo  <= 8'h00;
         end
      end
      else
      begin
         if (sclk_rise)
         begin
            bit_cnt  <= bit_cnt + 3'd1;
            shift_in <= new_byte;
         end
         if (byte_done)
         begin
            if (nbytes != 3'd7)
               nbytes <= nbytes + 3'd1;
            case (nbytes)
               3'd0:          opcode   <= new_byte;
               `IDX_ADDR_HI:  addr_hi  <= new_byte;
               `IDX_ADDR_MID: addr_mid <= new_byte;
               `IDX_ADDR_LO:  addr_lo  <= new_byte;
               default:       addr_lo  <= pb_we ? addr_lo + 8'd1 : addr_lo;
            endcase
            // stream starts after the dummy byte
            if (nbytes == `IDX_DUMMY && opcode == `OP_SEC_READ && state != ST_RESET)
               streaming <= 1'b1;
         end
         if (sclk_fall && streaming)
         begin
            if (aligned)
            begin
               shift_out <= mem[{addr_mid[1:0], addr_lo}];
               addr_lo   <= addr_lo + 8'd1;
            end
            else
               shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program staging buffer
   genvar i;
   generate
      for (i = 0; i < `SEC_PAGE_BYTES; i = i + 1)
      begin : g_buf
         always @(posedge mclk)
         begin
            if (!rst_n || pb_clr)
            begin
               pbuf[i]  <= `SEC_ERASED;
               pmask[i] <= 1'b0;
            end
            else if (pb_we && addr_lo == i)
            begin
               pbuf[i]  <= new_byte;
               pmask[i] <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // four security pages in flip-flops
   generate
      for (i = 0; i < `SEC_PAGES*`SEC_PAGE_BYTES; i = i + 1)
      begin : g_mem
         always @(posedge mclk)
         begin
            if (!rst_n)
               mem[i] <= `SEC_ERASED;
            else if (sec_done && op_page == i / `SEC_PAGE_BYTES)
            begin
               if (state == ST_ERASE)
                  mem[i] <= `SEC_ERASED;
               else if (pmask[i % `SEC_PAGE_BYTES])
                  mem[i] <= mem[i] & pbuf[i % `SEC_PAGE_BYTES];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // command execution, timed cycles and status flags
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state             <= ST_IDLE;
         timer             <= 24'd0;
         op_page           <= 2'd0;
         write_latch_armed <= 1'b0;
         charge_pump_mode  <= 1'b0;
         paused_op_flag    <= 1'b0;
         paused_is_erase   <= 1'b0;
         halted            <= 1'b0;
         pause_cnt         <= 12'd0;
         reset_armed       <= 1'b0;
         array_hold        <= 1'b0;
         array_abort       <= 1'b0;
         volatile_clear    <= 1'b0;
         op_in_progress    <= 1'b0;
         soft_reset_busy   <= 1'b0;
         fwd_opcode        <= 8'h00;
         fwd_strobe        <= 1'b0;
         cmd_refused       <= 1'b0;
      end
      else
      begin
         array_abort    <= 1'b0;
         volatile_clear <= 1'b0;
         fwd_strobe     <= 1'b0;
         cmd_refused    <= 1'b0;
         op_in_progress <= sec_busy | (array_busy & ~halted);
         soft_reset_busy <= (state == ST_RESET);
         // busy drops once the pause latency has run
         if (paused_op_flag && !halted)
         begin
            if (pause_cnt == 12'd0)
               halted <= 1'b1;
            else
               pause_cnt <= pause_cnt - 12'd1;
         end
         // timed cycle countdown
         if (state != ST_IDLE)
         begin
            timer <= timer - 24'd1;
            if (timer == 24'd1)
               state <= ST_IDLE;
         end
         // frames are ignored while the reset runs
         if (sel_rise && nbytes != 3'd0 && state != ST_RESET)
         begin
            reset_armed <= 1'b0;
            if (refused && aligned)
               cmd_refused <= 1'b1;
            else if (opcode == `OP_WRITE_ARM && single)
               write_latch_armed <= 1'b1;
            // pump mode after three dummy bytes
            else if (opcode == `OP_PUMP_MODE && aligned && nbytes == `LEN_PUMP)
               charge_pump_mode <= 1'b1;
            else if ((opcode == `OP_RELEASE || opcode == `OP_POWER_DOWN) && aligned)
            begin
               charge_pump_mode <= 1'b0;
               fwd_opcode       <= opcode;
               fwd_strobe       <= 1'b1;
            end
            else if (opcode == `OP_PAUSE && single)
            begin
               if (array_busy && !paused_op_flag && op_in_progress)
               begin
                  paused_op_flag  <= 1'b1;
                  paused_is_erase <= array_is_erase;
                  array_hold      <= 1'b1;
                  pause_cnt       <= PAUSE_LOAD[11:0];
               end
            end
            else if (opcode == `OP_CONTINUE && single)
            begin
               if (paused_op_flag && !op_in_progress)
               begin
                  // resume at once, well inside the bound
                  paused_op_flag <= 1'b0;
                  halted         <= 1'b0;
                  array_hold     <= 1'b0;
                  op_in_progress <= array_busy;
               end
            end
            // exact three address bytes, start cycle
            else if (opcode == `OP_SEC_ERASE && aligned && nbytes == `LEN_SEC_ERASE)
            begin
               if (sec_ok)
               begin
                  state             <= ST_ERASE;
                  timer             <= ERASE_LOAD[23:0];
                  op_page           <= addr_mid[1:0];
                  write_latch_armed <= 1'b0;
               end
            end
            // at least one data byte, start cycle
            else if (opcode == `OP_SEC_PROG && aligned && nbytes >= `LEN_SEC_PROG_MIN)
            begin
               if (prog_ok)
               begin
                  state             <= ST_PROG;
                  timer             <= WRITE_LOAD[23:0];
                  op_page           <= addr_mid[1:0];
                  write_latch_armed <= 1'b0;
               end
            end
            // arm, then reset in the next frame
            else if (opcode == `OP_RESET_ENABLE && single)
               reset_armed <= 1'b1;
            else if (opcode == `OP_RESET && single && reset_armed)
            begin
               state             <= ST_RESET;
               timer             <= RESET_LOAD[23:0];
               write_latch_armed <= 1'b0;
               charge_pump_mode  <= 1'b0;
               paused_op_flag    <= 1'b0;
               halted            <= 1'b0;
               array_hold        <= 1'b0;
               array_abort       <= 1'b1;
               volatile_clear    <= 1'b1;
               op_in_progress    <= 1'b0;
            end
            else if (opcode != `OP_SEC_READ && opcode != `OP_PUMP_MODE &&
                     opcode != `OP_SEC_ERASE && opcode != `OP_SEC_PROG)
            begin
               fwd_opcode <= opcode;
               fwd_strobe <= 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: testbench/flash_seq_asserts.sv */
// checker for the flash command sequencer
// sees only the top module ports; bound to every instance below
`timescale 1ns/100ps
`include "flash_seq_consts.vh"
`default_nettype none

module flash_seq_asserts
#(
   parameter SOFT_RESET_CYC = 60
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // array engine side
   input wire logic array_busy,
   input wire logic array_hold,
   input wire logic array_abort,
   // status flags
   input wire logic otp_lock_flag,
   input wire logic op_in_progress,
   input wire logic paused_op_flag,
   input wire logic write_latch_armed,
   input wire logic volatile_clear,
   input wire logic soft_reset_busy,
   // command results
   input wire logic fwd_strobe,
   input wire logic cmd_refused
);
   localparam int PAUSE_MAX = `PAUSE_LATENCY_CYC + 2;
   int            pause_cnt;
   int            srb_cnt;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // cycles paused while busy still shows, and soft reset length
   always @(posedge mclk)
   begin
      pause_cnt <= (rst_n && paused_op_flag && op_in_progress) ? pause_cnt + 1 : 0;
      srb_cnt <= (rst_n && soft_reset_busy) ? srb_cnt + 1 : 0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_pause_cause; $rose(paused_op_flag) |-> $past(array_busy); endproperty
   a_pause_cause: assert property (p_pause_cause)
      else $error("pause taken with no array operation");
   property p_pause_hold; paused_op_flag == array_hold; endproperty
   a_pause_hold: assert property (p_pause_hold)
      else $error("array hold differs from paused flag");
   property p_pause_drop; pause_cnt <= PAUSE_MAX; endproperty
   a_pause_drop: assert property (p_pause_drop)
      else $error("busy still shown past pause latency");
   property p_resume;
      $fell(paused_op_flag) && !array_abort && !$past(array_abort)
         |-> ##[0:2] (op_in_progress == array_busy);
   endproperty
   a_resume: assert property (p_resume)
      else $error("busy not restored after continue");
   property p_refuse; cmd_refused |-> paused_op_flag; endproperty
   a_refuse: assert property (p_refuse)
      else $error("refusal outside a pause");
   property p_latch_end;
      $fell(op_in_progress) && !$past(array_busy) |-> !write_latch_armed;
   endproperty
   a_latch_end: assert property (p_latch_end)
      else $error("write latch still armed after security cycle");
   property p_lock; $rose(op_in_progress) && !array_busy |-> !otp_lock_flag; endproperty
   a_lock: assert property (p_lock)
      else $error("security cycle started while locked");
   property p_abort;
      array_abort |-> volatile_clear ##1 (!paused_op_flag && !write_latch_armed);
   endproperty
   a_abort: assert property (p_abort)
      else $error("soft reset left volatile state");
   property p_quiet;
      soft_reset_busy |-> !fwd_strobe && !cmd_refused && !$rose(write_latch_armed);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("command taken during soft reset");
   property p_srb_len;
      $fell(soft_reset_busy) |-> srb_cnt >= SOFT_RESET_CYC - 1 && srb_cnt <= SOFT_RESET_CYC + 1;
   endproperty
   a_srb_len: assert property (p_srb_len)
      else $error("soft reset time wrong length");
endmodule

bind flash_seq flash_seq_asserts #(.SOFT_RESET_CYC(SOFT_RESET_CYC)) u_flash_seq_asserts (
   .mclk(mclk), .rst_n(rst_n), .array_busy(array_busy), .array_hold(array_hold),
   .array_abort(array_abort), .otp_lock_flag(otp_lock_flag), .op_in_progress(op_in_progress),
   .paused_op_flag(paused_op_flag), .write_latch_armed(write_latch_armed),
   .volatile_clear(volatile_clear), .soft_reset_busy(soft_reset_busy),
   .fwd_strobe(fwd_strobe), .cmd_refused(cmd_refused)
);
`default_nettype wire

/* File: testbench/spi_host_model.sv */
// host serial controller model: mode 0, msb first, whole frames
// assumes the bench fills tx before calling frame
`timescale 1ns/100ps
`default_nettype none

module spi_host_model
(
   // clock
   input wire logic mclk,
   // link
   input wire logic sdo,
   output var logic sel_n,
   output var logic sclk,
   output var logic sdi
);
   logic [7:0] tx[$];
   logic [7:0] rx[$];

   // idle link: deselected, clock low
   initial
   begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   task automatic half(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic frame(input int nbits);
      logic [7:0] sh;
      int         i;
      sel_n = 1'b0;
      half(4);
      for (i = 0; i < nbits; i++)
      begin
         sdi = tx[i / 8][7 - i % 8];
         half(16);
         sclk = 1'b1;
         sh = {sh[6:0], sdo};
         if (i % 8 == 7)
            rx.push_back(sh);
         half(16);
         sclk = 1'b0;
      end
      half(4);
      sel_n = 1'b1;
      sdi = ~sdi;
      half(8);
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the flash command sequencer
// host model drives the link; the array engine is played by the bench
`timescale 1ns/100ps
`include "flash_seq_consts.vh"
`default_nettype none

module testbench;
   logic       mclk, rst_n, array_busy, array_is_erase, otp_lock_flag;
   wire        sel_n_pin, sclk_pin, sdi_pin, sdo, sdo_oe, array_hold, array_abort;
   wire        op_in_progress, paused_op_flag, write_latch_armed, charge_pump_mode;
   wire        volatile_clear, soft_reset_busy, fwd_strobe, cmd_refused;
   wire [7:0]  fwd_opcode;
   int         mem[4][256];
   int         fails, n_checks, cyc, nref, nfwd, nvc, nab, p, r, f, v, k, e, o, noe;
   logic [7:0] rel[2] = '{8'hB9, 8'hAB};
   logic [7:0] ops[10] = '{8'h01, 8'h44, 8'h42, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32};
   int         lens[10] = '{2, 4, 5, 4, 4, 4, 1, 1, 5, 5};
   logic       ok;
   logic [7:0] q[$];

   flash_seq #(.SEC_ERASE_CYC(50), .SEC_WRITE_CYC(40), .SOFT_RESET_CYC(600)) u_flash_seq (
      .mclk(mclk), .rst_n(rst_n), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
      .sdi_pin(sdi_pin), .sdo(sdo), .sdo_oe(sdo_oe), .array_busy(array_busy),
      .array_is_erase(array_is_erase), .array_hold(array_hold), .array_abort(array_abort),
      .otp_lock_flag(otp_lock_flag), .op_in_progress(op_in_progress),
      .paused_op_flag(paused_op_flag), .write_latch_armed(write_latch_armed),
      .charge_pump_mode(charge_pump_mode), .volatile_clear(volatile_clear),
      .soft_reset_busy(soft_reset_busy), .fwd_opcode(fwd_opcode), .fwd_strobe(fwd_strobe),
      .cmd_refused(cmd_refused));
   spi_host_model u_spi_host_model (
      .mclk(mclk), .sdo(sdo), .sel_n(sel_n_pin), .sclk(sclk_pin), .sdi(sdi_pin));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (fails == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic go(input logic [7:0] b[$], input int cut = 0);
      u_spi_host_model.tx = b;
      u_spi_host_model.rx.delete();
      u_spi_host_model.frame(8 * b.size() - cut);
      tick(2);
   endtask
   task automatic idle;
      int i;
      for (i = 0; i < 400 && op_in_progress !== 1'b0; i++)
         tick(1);
      chk("op_in_progress", 0, op_in_progress);
   endtask
   // read n bytes and compare with the page model
   task automatic rd(input int pg, input int off, input int n);
      logic [7:0] b[$];
      int         i;
      b = {8'h48, 8'h00, 8'(pg), 8'(off), 8'h00};
      o = noe;
      for (i = 0; i < n; i++)
         b.push_back(8'h00);
      go(b);
      for (i = 0; i < n; i++)
         chk("read byte", mem[pg][(off + i) % 256], u_spi_host_model.rx[5 + i]);
      chk("sdo_oe", 1, noe > o);
   endtask
   // program n random bytes; model updated only if the write should land
   task automatic prog(input int pg, input int off, input int n, input bit apply);
      logic [7:0] b[$];
      logic [7:0] d;
      int         i;
      b = {8'h42, 8'h00, 8'(pg), 8'(off)};
      for (i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         b.push_back(d);
         if (apply)
            mem[pg][(off + i) % 256] &= d;
      end
      go(b);
   endtask

   // clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // pulse counters and run limit
   always @(posedge mclk)
   begin
      nref += (cmd_refused === 1'b1);
      nfwd += (fwd_strobe === 1'b1);
      nvc += (volatile_clear === 1'b1);
      nab += (array_abort === 1'b1);
      noe += (sdo_oe === 1'b1);
      cyc++;
      if (cyc == 95000)
      begin
         fails++;
         end_sim();
      end
   end

   // main sequence
   initial
   begin
      rst_n = 1'b0;
      array_busy = 1'b0;
      array_is_erase = 1'b0;
      otp_lock_flag = 1'b0;
      void'($urandom(32'hfec6_ec4f));
      foreach (mem[i, j])
         mem[i][j] = 255;
      tick(2);
      rst_n = 1'b1;
      tick(4);
      chk("flags", 0, {op_in_progress, paused_op_flag, write_latch_armed, charge_pump_mode});
      foreach (rel[i])
      begin
         go({8'hA3, 8'h00, 8'h00});
         chk("pump short", 0, charge_pump_mode);
         go({8'hA3, 8'h00, 8'h00, 8'h00});
         chk("pump", 1, charge_pump_mode);
         go({rel[i]});
         chk("pump off", 0, charge_pump_mode);
      end
      go({8'h06, 8'h00}, 7);
      chk("latch 9 bits", 0, write_latch_armed);
      prog(1, 0, 2, 0);
      chk("unarmed prog", 0, op_in_progress);
      go({8'h06});
      chk("latch", 1, write_latch_armed);
      p = $urandom_range(3);
      prog(p, 8'hFE, 3, 1);
      chk("prog busy", 1, op_in_progress);
      chk("latch cleared", 0, write_latch_armed);
      idle();
      rd(p, 8'hFD, 5);
      rd((p + 1) % 4, 8'hFF, 2);
      go({8'h06});
      go({8'h44, 8'h00, 8'(p), 8'h00, 8'h00});
      chk("erase long", 0, op_in_progress);
      go({8'h44, 8'h00, 8'h04, 8'h00});
      chk("erase page 4", 0, op_in_progress);
      go({8'h44, 8'h00, 8'(p), 8'h00});
      chk("erase busy", 1, op_in_progress);
      idle();
      for (k = 0; k < 256; k++)
         mem[p][k] = 255;
      rd(p, 8'hFE, 3);
      array_busy = 1'b1;
      for (e = 0; e < 2; e++)
      begin
         array_is_erase = e[0];
         tick(4);
         go({8'h75});
         chk("paused", 1, paused_op_flag);
         go({8'h7A});
         chk("early continue", 1, paused_op_flag);
         tick(`PAUSE_LATENCY_CYC);
         chk("paused busy", 0, op_in_progress);
         foreach (ops[i])
         begin
            r = nref;
            f = nfwd;
            q = {ops[i]};
            for (k = 1; k < lens[i]; k++)
               q.push_back(8'h00);
            go(q);
            ok = e && (ops[i] == 8'h42 || ops[i] == 8'h02 || ops[i] == 8'h32);
            chk("refused", !ok, nref - r);
            chk("forwarded", ok && ops[i] != 8'h42, nfwd - f);
            if (ok && ops[i] != 8'h42)
               chk("fwd opcode", ops[i], fwd_opcode);
         end
         go({8'h75});
         chk("second pause", 1, paused_op_flag);
         go({8'h7A});
         chk("continued", 0, paused_op_flag);
         chk("resumed busy", 1, op_in_progress);
      end
      array_busy = 1'b0;
      tick(4);
      go({8'h75});
      chk("idle pause", 0, paused_op_flag);
      array_busy = 1'b1;
      go({8'h75});
      go({8'h06});
      chk("paused before reset", 1, paused_op_flag);
      v = nvc;
      go({8'h99});
      go({8'h66});
      go({8'h06});
      go({8'h99});
      chk("unarmed reset", v, nvc);
      go({8'h66});
      go({8'h99});
      chk("volatile clear", v + 1, nvc);
      chk("abort", 1, nab);
      array_busy = 1'b0;
      chk("cleared", 0, {paused_op_flag, write_latch_armed, array_hold});
      chk("reset busy", 1, soft_reset_busy);
      go({8'h06});
      chk("latch in reset", 0, write_latch_armed);
      tick(600);
      go({8'h06});
      chk("latch after reset", 1, write_latch_armed);
      otp_lock_flag = 1'b1;
      prog(p, 0, 1, 0);
      chk("locked prog", 0, op_in_progress);
      go({8'h44, 8'h00, 8'(p), 8'h00});
      chk("locked erase", 0, op_in_progress);
      rd(p, 8'h00, 2);
      end_sim();
   end
endmodule
`default_nettype wire
